// ==== src/readout_pkg.sv ====
// Shared constants for the sensor readout path and its receiver.
// Assumes both ends run on one 10 MHz master clock from the bench.
package readout_pkg;
    // ************************************************************
    // Array and lane geometry
    // ************************************************************
    localparam int ROWS = 2048;
    localparam int COLS = 2048;
    localparam int LANES = 16;
    localparam int COLS_PER_LANE = 128;
    localparam int OUT_PAIRS = LANES + 2;
    localparam int ROW_W = 11;
    localparam int COL_W = 7;
    localparam int LANE_W = 4;
    localparam logic [COL_W-1:0] COL_LAST = 7'h7F;

    // ************************************************************
    // Word formats
    // ************************************************************
    localparam int WORD10 = 10;
    localparam int WORD12 = 12;
    localparam int WORD_MAX = WORD12;
    localparam logic [WORD_MAX-1:0] CODE_MAX10 = 12'h3FF;
    localparam logic [WORD_MAX-1:0] CODE_MAX12 = 12'hFFF;
    localparam int ALIGN10 = WORD12 - WORD10;
    localparam int CTRL_DVAL = 11;
    localparam int CTRL_LVAL = 10;
    localparam int CTRL_FVAL = 9;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int MCLK_KHZ = 10000;
    localparam int LANE_MAX_KBPS = 480000;
    localparam int LINK_HALF_CYCLES = 4;
    localparam int LANE_KBPS = MCLK_KHZ / LINK_HALF_CYCLES;
    localparam logic [1:0] LINK_LOAD_PHASE = 2'h0;
    localparam logic [1:0] LINK_EDGE_PHASE = 2'h2;
    localparam logic [1:0] LINK_LAST_PHASE = 2'h3;
    localparam logic [3:0] SPI_HALF_LAST = 4'h7;
    localparam logic [3:0] SPI_BYTE_LAST = 4'h7;
    localparam logic [4:0] RESET_HOLD_CYCLES = 5'h10;
    localparam logic [1:0] FRAME_REQ_HOLD = 2'h2;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 7;
    localparam int TEMP_W = 16;
    localparam int CFG_REGS = 7;
    localparam int REG_FRAMES = 0;
    localparam int REG_WIN_START = 1;
    localparam int REG_WIN_ROWS = 2;
    localparam int REG_SUBSAMPLE = 3;
    localparam int REG_GAIN = 4;
    localparam int REG_OFFSET = 5;
    localparam int REG_MODE = 6;
    localparam logic [ADDR_W-1:0] ADDR_TEMP_A = 7'h7E;
    localparam logic [ADDR_W-1:0] ADDR_TEMP_B = 7'h7F;
    localparam logic [7:0] RST_FRAMES = 8'h01;
    localparam logic [7:0] RST_WIN_ROWS = 8'hFF;
    localparam int WIN_SHIFT = 3;
    localparam int MODE_RES12_BIT = 0;
    localparam int SUB_EN_BIT = 0;
    localparam int SPI_WRITE_BIT = 7;
endpackage

// ==== src/readout_if.sv ====
// Pins between the sensor end and the receiver/controller end.
// Assumes the bench joins both ends and supplies the master clock.
`timescale 1ns/100ps
interface readout_if;
    logic [readout_pkg::LANES-1:0] lane_data;
    logic lane_ctrl;
    logic lane_clk;
    logic spi_clk;
    logic spi_en;
    logic spi_in;
    logic spi_out;
    logic frame_req;
    logic system_reset_low;

    modport sensor (
        output lane_data, lane_ctrl, lane_clk, spi_out,
        input spi_clk, spi_en, spi_in, frame_req, system_reset_low
    );
    modport receiver (
        input lane_data, lane_ctrl, lane_clk, spi_out,
        output spi_clk, spi_en, spi_in, frame_req, system_reset_low
    );
endinterface

// ==== src/image_sensor_end.sv ====
// Sensor end: sequencer, pixel coding, lane serialiser and SPI registers.
// Assumes all link inputs are asynchronous pins; temperature input is local.
`timescale 1ns/100ps
// Notes on behaviour
// - Frame read out row after row, 2048x2048.
// - Each lane carries its own 128 columns.
// - Sixteen data lanes, one control, one clock.
// - Lane bit rate stays at most 480 Mbps.
// - Lane words are 10 or 12 bits.
// - DDR clock centred on data; receiver samples with it.
// - Control lane tells data, line, frame validity.
// - Converter code plus programmed digital offset.
// - Controller loads registers; sequencer uses them.
// - Window, subsample, gain, offset set by registers.
// - Configuration registers read back over SPI.
// - Temperature in registers 126, 127, burst read.
// - Temperature keeps working while sensor idles.
// - Inputs sampled on master clock rising edge.
// - Active-low reset clears sequencer, held at start.
// - Frame request high captures programmed frame count.
module image_sensor_end
    import readout_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Temperature sensor sample
    input wire logic [TEMP_W-1:0] temp_sample_i,
    // Status
    output logic busy_o,
    // Pins toward the receiver
    readout_if.sensor link
);
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_ROW, SEQ_GAP} seq_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic req_s1;
        logic req_s2;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic en_s1;
        logic en_s2;
        logic din_s1;
        logic din_s2;
        logic hdr_done;
        logic [3:0] bit_cnt;
        logic [7:0] hdr;
        logic [7:0] rx;
        logic [7:0] tx;
        logic spi_out;
        logic [CFG_REGS-1:0][7:0] cfg;
        logic [TEMP_W-1:0] temp_snap;
        seq_t seq;
        logic req_pend;
        logic [7:0] frames_left;
        logic [ROW_W-1:0] row;
        logic [ROW_W:0] rows_left;
        logic [COL_W-1:0] col;
        logic res12;
        logic fval;
        logic [1:0] phase;
        logic [3:0] bit_idx;
        logic lclk;
        logic [LANES-1:0][WORD_MAX-1:0] sh;
        logic [WORD_MAX-1:0] ctrl;
        logic busy;
    } state_t;

    state_t s;
    state_t next_s;
    logic [LANES-1:0][WORD_MAX-1:0] pix;

    // ************************************************************
    // Pixel coding
    // ************************************************************
    // Stand-in for the analog column value, then gain, offset, clamp
    function automatic logic [WORD_MAX-1:0] pixel_code(
        input logic [ROW_W-1:0] row,
        input logic [COL_W-1:0] col,
        input logic [LANE_W-1:0] lane,
        input logic res12,
        input logic [7:0] gain,
        input logic [7:0] offs
    );
        logic [WORD_MAX-1:0] raw;
        logic [WORD_MAX-1:0] code;
        logic [WORD_MAX-1:0] top;
        logic [15:0] gained;
        logic [16:0] sum;
        raw = {row[5:0], lane[1:0], col[3:0]};
        code = res12 ? raw : {2'h0, raw[WORD_MAX-1:ALIGN10]};
        top = res12 ? CODE_MAX12 : CODE_MAX10;
        gained = {4'h0, code} << gain[1:0];
        sum = {1'b0, gained} + {9'h000, offs};
        pixel_code = (sum > {5'h00, top}) ? top : sum[WORD_MAX-1:0];
    endfunction

    // Lane l serves columns l*128 .. l*128+127
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign pix[l] = pixel_code(s.row, s.col, LANE_W'(l), s.res12,
            s.cfg[REG_GAIN], s.cfg[REG_OFFSET]);
        assign link.lane_data[l] = s.sh[l][WORD_MAX-1];
    end

    assign link.lane_ctrl = s.ctrl[WORD_MAX-1];
    assign link.lane_clk = s.lclk;
    assign link.spi_out = s.spi_out;
    assign busy_o = s.busy;

    // ************************************************************
    // Register read mux
    // ************************************************************
    function automatic logic [7:0] reg_read(
        input logic [ADDR_W-1:0] addr,
        input logic [CFG_REGS-1:0][7:0] cfg,
        input logic [TEMP_W-1:0] temp
    );
        if (addr < ADDR_W'(CFG_REGS)) begin
            reg_read = cfg[addr[2:0]];
        end else if (addr == ADDR_TEMP_A) begin
            reg_read = temp[7:0];
        end else if (addr == ADDR_TEMP_B) begin
            reg_read = temp[15:8];
        end else begin
            reg_read = 8'h00;
        end
    endfunction

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic rise;
        logic [7:0] hdr_n;
        logic [7:0] rx_n;
        logic [ADDR_W-1:0] addr_n;
        logic [TEMP_W-1:0] temp_n;
        logic [3:0] last_bit;
        next_s = s;
        rise = 1'b0;
        hdr_n = 8'h00;
        rx_n = 8'h00;
        addr_n = '0;
        temp_n = s.temp_snap;
        last_bit = s.res12 ? 4'(WORD12 - 1) : 4'(WORD10 - 1);

        // Pin synchronisers
        next_s.rst_s1 = link.system_reset_low;
        next_s.rst_s2 = s.rst_s1;
        next_s.req_s1 = link.frame_req;
        next_s.req_s2 = s.req_s1;
        next_s.sclk_s1 = link.spi_clk;
        next_s.sclk_s2 = s.sclk_s1;
        next_s.sclk_s3 = s.sclk_s2;
        next_s.en_s1 = link.spi_en;
        next_s.en_s2 = s.en_s1;
        next_s.din_s1 = link.spi_in;
        next_s.din_s2 = s.din_s1;
        rise = s.sclk_s2 & ~s.sclk_s3;

        // SPI slave: header (write bit, address), then data bytes, burst
        if (!s.en_s2) begin
            next_s.bit_cnt = 4'h0;
            next_s.hdr_done = 1'b0;
        end else if (rise && !s.hdr_done) begin
            hdr_n = {s.hdr[6:0], s.din_s2};
            next_s.hdr = hdr_n;
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == SPI_BYTE_LAST) begin
                next_s.hdr_done = 1'b1;
                next_s.bit_cnt = 4'h0;
                if (!hdr_n[SPI_WRITE_BIT]) begin
                    if (hdr_n[ADDR_W-1:0] == ADDR_TEMP_A) begin
                        temp_n = temp_sample_i;
                    end
                    next_s.temp_snap = temp_n;
                    next_s.tx = reg_read(hdr_n[ADDR_W-1:0], s.cfg, temp_n);
                    next_s.spi_out = next_s.tx[7];
                end
            end
        end else if (rise) begin
            rx_n = {s.rx[6:0], s.din_s2};
            next_s.rx = rx_n;
            addr_n = s.hdr[ADDR_W-1:0];
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            next_s.tx = {s.tx[6:0], 1'b0};
            next_s.spi_out = s.tx[6];
            if (s.bit_cnt == SPI_BYTE_LAST) begin
                next_s.bit_cnt = 4'h0;
                if (s.hdr[SPI_WRITE_BIT] && addr_n < ADDR_W'(CFG_REGS)) begin
                    next_s.cfg[addr_n[2:0]] = rx_n;
                end
                next_s.hdr = {s.hdr[7], addr_n + 7'h01};
                next_s.tx = reg_read(addr_n + 7'h01, s.cfg, s.temp_snap);
                next_s.spi_out = next_s.tx[7];
            end
        end

        // Frame request: a high level sets the request, set wins
        next_s.req_pend = s.req_pend | s.req_s2;

        // Link timing: data moves at phase 0, clock edge at phase 2
        next_s.phase = (s.phase == LINK_LAST_PHASE) ? LINK_LOAD_PHASE : s.phase + 2'h1;
        if (s.phase == LINK_EDGE_PHASE) begin
            next_s.lclk = ~s.lclk;
        end
        if (s.phase == LINK_LOAD_PHASE) begin
            // One bit per clock edge, well below the lane limit
            next_s.bit_idx = (s.bit_idx == last_bit) ? 4'h0 : s.bit_idx + 4'h1;
            next_s.sh = s.sh << 1;
            next_s.ctrl = s.ctrl << 1;
            if (s.bit_idx == 4'h0) begin
                next_s.sh = '0;
                next_s.ctrl = '0;
                case (s.seq)
                    SEQ_IDLE: begin
                        next_s.res12 = s.cfg[REG_MODE][MODE_RES12_BIT];
                        next_s.fval = 1'b0;
                        if (s.frames_left != 8'h00 || s.req_pend) begin
                            next_s.seq = SEQ_ROW;
                            next_s.fval = 1'b1;
                            next_s.col = '0;
                            next_s.row = {s.cfg[REG_WIN_START], 3'h0};
                            next_s.rows_left = 12'(({4'h0, s.cfg[REG_WIN_ROWS]} + 12'h001)
                                << WIN_SHIFT) >> s.cfg[REG_SUBSAMPLE][SUB_EN_BIT];
                            if (s.frames_left == 8'h00) begin
                                next_s.req_pend = s.req_s2;
                                next_s.frames_left = (s.cfg[REG_FRAMES] == 8'h00) ?
                                    8'h01 : s.cfg[REG_FRAMES];
                            end
                        end
                    end
                    SEQ_ROW: begin
                        for (int l = 0; l < LANES; l++) begin
                            next_s.sh[l] = s.res12 ? pix[l] : pix[l] << ALIGN10;
                        end
                        next_s.ctrl[CTRL_DVAL] = 1'b1;
                        next_s.ctrl[CTRL_LVAL] = 1'b1;
                        next_s.ctrl[CTRL_FVAL] = 1'b1;
                        next_s.col = s.col + 7'h01;
                        if (s.col == COL_LAST) begin
                            next_s.seq = SEQ_GAP;
                        end
                    end
                    SEQ_GAP: begin
                        next_s.ctrl[CTRL_FVAL] = 1'b1;
                        next_s.row = s.row + ROW_W'(11'h001 << s.cfg[REG_SUBSAMPLE][SUB_EN_BIT]);
                        next_s.rows_left = s.rows_left - 12'h001;
                        next_s.seq = SEQ_ROW;
                        if (s.rows_left == 12'h001) begin
                            next_s.seq = SEQ_IDLE;
                            next_s.frames_left = s.frames_left - 8'h01;
                        end
                    end
                    default: begin
                        next_s.seq = SEQ_IDLE;
                    end
                endcase
            end
        end
        next_s.busy = (next_s.seq != SEQ_IDLE) || (next_s.frames_left != 8'h00);

        // Reset clears the sequencer; its own synchroniser keeps running
        if (!rstn_i || !s.rst_s2) begin
            next_s = '0;
            next_s.seq = SEQ_IDLE;
            next_s.cfg[REG_FRAMES] = RST_FRAMES;
            next_s.cfg[REG_WIN_ROWS] = RST_WIN_ROWS;
            if (rstn_i) begin
                next_s.rst_s1 = link.system_reset_low;
                next_s.rst_s2 = s.rst_s1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        s <= next_s;
    end
endmodule // image_sensor_end

// ==== src/image_receiver_end.sv ====
// Receiver/controller end: start-up reset, frame request, SPI master, lane capture.
// Assumes the user keeps res12_i equal to the mode written to the sensor.
`timescale 1ns/100ps
module image_receiver_end
    import readout_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Register commands
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic cmd_temp_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [7:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rd_valid_o,
    output logic [TEMP_W-1:0] rd_data_o,
    // Frame control
    input wire logic frame_start_i,
    input wire logic res12_i,
    // Captured pixels
    output logic pix_valid_o,
    output logic pix_line_o,
    output logic pix_frame_o,
    output logic [LANES-1:0][WORD_MAX-1:0] pix_data_o,
    // Pins toward the sensor
    readout_if.receiver link
);
    typedef enum logic [1:0] {SPI_IDLE, SPI_XFER, SPI_END} spi_t;

    typedef struct packed {
        logic [4:0] hold;
        logic sys_rst_low;
        logic [1:0] req_cnt;
        logic frame_req;
        spi_t spi;
        logic [3:0] div;
        logic [4:0] nbits;
        logic [4:0] done_bits;
        logic [23:0] tx;
        logic [15:0] rx;
        logic temp;
        logic sclk;
        logic en;
        logic din;
        logic ready;
        logic rd_valid;
        logic [TEMP_W-1:0] rd_data;
        logic sdo_s1;
        logic sdo_s2;
        logic lclk_s1;
        logic lclk_s2;
        logic lclk_s3;
        logic [LANES:0] dat_s1;
        logic [LANES:0] dat_s2;
        logic [3:0] bit_cnt;
        logic [LANES:0][WORD_MAX-1:0] sr;
        logic pix_valid;
        logic pix_line;
        logic pix_frame;
        logic [LANES-1:0][WORD_MAX-1:0] pix;
    } state_t;

    state_t s;
    state_t next_s;

    assign link.system_reset_low = s.sys_rst_low;
    assign link.frame_req = s.frame_req;
    assign link.spi_clk = s.sclk;
    assign link.spi_en = s.en;
    assign link.spi_in = s.din;
    assign cmd_ready_o = s.ready;
    assign rd_valid_o = s.rd_valid;
    assign rd_data_o = s.rd_data;
    assign pix_valid_o = s.pix_valid;
    assign pix_line_o = s.pix_line;
    assign pix_frame_o = s.pix_frame;
    assign pix_data_o = s.pix;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [3:0] last_bit;
        logic [LANES:0][WORD_MAX-1:0] sr_n;
        logic [WORD_MAX-1:0] ctrl;
        next_s = s;
        sr_n = s.sr;
        ctrl = '0;
        last_bit = res12_i ? 4'(WORD12 - 1) : 4'(WORD10 - 1);
        next_s.rd_valid = 1'b0;
        next_s.pix_valid = 1'b0;

        // Sensor held in reset through start-up
        if (s.hold != RESET_HOLD_CYCLES) begin
            next_s.hold = s.hold + 5'h01;
        end
        next_s.sys_rst_low = (s.hold == RESET_HOLD_CYCLES);

        // Frame request held for more than one master clock period
        next_s.frame_req = (s.req_cnt != 2'h0);
        if (s.req_cnt != 2'h0) begin
            next_s.req_cnt = s.req_cnt - 2'h1;
        end else if (frame_start_i && s.sys_rst_low) begin
            next_s.req_cnt = FRAME_REQ_HOLD;
        end

        // SPI master: data set on falling edge, read sampled at rising edge
        next_s.sdo_s1 = link.spi_out;
        next_s.sdo_s2 = s.sdo_s1;
        case (s.spi)
            SPI_IDLE: begin
                if (cmd_valid_i && s.ready) begin
                    next_s.spi = SPI_XFER;
                    next_s.ready = 1'b0;
                    next_s.en = 1'b1;
                    next_s.temp = cmd_temp_i & ~cmd_write_i;
                    next_s.nbits = (cmd_temp_i && !cmd_write_i) ? 5'h18 : 5'h10;
                    next_s.tx = {cmd_write_i, cmd_temp_i && !cmd_write_i ? ADDR_TEMP_A :
                        cmd_addr_i, cmd_write_i ? cmd_wdata_i : 8'h00, 8'h00};
                    next_s.din = cmd_write_i;
                    next_s.div = 4'h0;
                    next_s.done_bits = 5'h00;
                    next_s.rx = 16'h0000;
                end
            end
            SPI_XFER: begin
                next_s.div = s.div + 4'h1;
                if (s.div == SPI_HALF_LAST) begin
                    next_s.div = 4'h0;
                    next_s.sclk = ~s.sclk;
                    if (!s.sclk) begin
                        next_s.done_bits = s.done_bits + 5'h01;
                        if (s.done_bits >= 5'h08) begin
                            next_s.rx = {s.rx[14:0], s.sdo_s2};
                        end
                    end else if (s.done_bits == s.nbits) begin
                        next_s.spi = SPI_END;
                    end else begin
                        next_s.tx = {s.tx[22:0], 1'b0};
                        next_s.din = s.tx[22];
                    end
                end
            end
            SPI_END: begin
                next_s.div = s.div + 4'h1;
                if (s.div == SPI_HALF_LAST) begin
                    next_s.spi = SPI_IDLE;
                    next_s.en = 1'b0;
                    next_s.ready = 1'b1;
                    next_s.rd_valid = ~s.tx[23];
                    next_s.rd_data = s.temp ? {s.rx[7:0], s.rx[15:8]} : {8'h00, s.rx[7:0]};
                end
            end
            default: begin
                next_s.spi = SPI_IDLE;
            end
        endcase

        // Lane capture on each edge of the forwarded clock
        next_s.lclk_s1 = link.lane_clk;
        next_s.lclk_s2 = s.lclk_s1;
        next_s.lclk_s3 = s.lclk_s2;
        next_s.dat_s1 = {link.lane_ctrl, link.lane_data};
        next_s.dat_s2 = s.dat_s1;
        if (s.lclk_s2 != s.lclk_s3) begin
            for (int l = 0; l <= LANES; l++) begin
                sr_n[l] = {s.sr[l][WORD_MAX-2:0], s.dat_s2[l]};
            end
            next_s.sr = sr_n;
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == last_bit) begin
                next_s.bit_cnt = 4'h0;
                ctrl = res12_i ? sr_n[LANES] : sr_n[LANES] << ALIGN10;
                next_s.pix_valid = ctrl[CTRL_DVAL];
                next_s.pix_line = ctrl[CTRL_LVAL];
                next_s.pix_frame = ctrl[CTRL_FVAL];
                if (ctrl[CTRL_DVAL]) begin
                    for (int l = 0; l < LANES; l++) begin
                        next_s.pix[l] = res12_i ? sr_n[l] : {2'h0, sr_n[l][WORD10-1:0]};
                    end
                end
            end
        end

        if (!rstn_i) begin
            next_s = '0;
            next_s.spi = SPI_IDLE;
        end else if (!s.sys_rst_low) begin
            next_s.ready = next_s.sys_rst_low;
        end
    end

    always_ff @(posedge mclk_i) begin
        s <= next_s;
    end
endmodule // image_receiver_end

// ==== dv/readout_monitor.sv ====
// Assertions on the pins between the sensor end and the receiver end.
// Assumes one master clock and its synchronous active-low reset.
`timescale 1ns/100ps
module readout_monitor
    import readout_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Link pins
    input wire logic [LANES-1:0] lane_data,
    input wire logic lane_ctrl,
    input wire logic lane_clk,
    input wire logic spi_clk,
    input wire logic spi_en,
    input wire logic spi_in,
    input wire logic frame_req,
    input wire logic system_reset_low
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    reset_stretch_a: assert property (disable iff (1'b0) $rose(rstn_i) |-> !system_reset_low [*8])
        else $error("sensor reset released too early");
    lanes_quiet_a: assert property ($rose(system_reset_low) |-> lane_data == '0 && !lane_clk)
        else $error("lanes active during reset");
    lane_clk_half_a: assert property ($changed(lane_clk) |=> $stable(lane_clk) [*3])
        else $error("lane clock half period wrong");
    data_before_clk_a: assert property ($changed(lane_data) |-> ##2 $changed(lane_clk))
        else $error("lane data not centred on clock edge");
    ctrl_bit_hold_a: assert property ($changed(lane_ctrl) |=> $stable(lane_ctrl) [*3])
        else $error("control bit held too short");
    spi_clk_half_a: assert property ($changed(spi_clk) |=> $stable(spi_clk) [*7])
        else $error("serial clock half period wrong");
    spi_idle_low_a: assert property (!spi_en |-> !spi_clk)
        else $error("serial clock moves while disabled");
    spi_data_fall_a: assert property (spi_en && $past(spi_en) && $changed(spi_in) |-> $fell(spi_clk))
        else $error("serial data changed off falling edge");
    frame_req_hold_a: assert property ($rose(frame_req) |=> frame_req)
        else $error("frame request shorter than two cycles");
    no_req_reset_a: assert property (!system_reset_low |-> !frame_req)
        else $error("frame request during sensor reset");
endmodule // readout_monitor

// ==== dv/test_image_readout_output_path.sv ====
// Bench joining both ends; drives the receiver user side.
// Assumes 10 MHz master clock and an 8-row subsampled window.
`timescale 1ns/100ps
module test_image_readout_output_path import readout_pkg::*;;
    logic mclk_i = 1'b0, rstn_i = 1'b0, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
    logic cmd_temp_i = 1'b0, frame_start_i = 1'b0, res12_i = 1'b0;
    logic [ADDR_W-1:0] cmd_addr_i = '0;
    logic [7:0] cmd_wdata_i = '0;
    logic [TEMP_W-1:0] temp_sample_i = '0, rd_data_o;
    logic busy_o, cmd_ready_o, rd_valid_o, pix_valid_o, pix_line_o, pix_frame_o;
    logic [LANES-1:0][WORD_MAX-1:0] pix_data_o;
    logic [7:0] cfg [CFG_REGS];
    int n_fail = 0, n_compared = 0;
    readout_if link ();
    image_sensor_end i_image_sensor_end (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .temp_sample_i(temp_sample_i), .busy_o(busy_o), .link(link));
    image_receiver_end i_image_receiver_end (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_temp_i(cmd_temp_i),
        .cmd_addr_i(cmd_addr_i), .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o),
        .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .frame_start_i(frame_start_i),
        .res12_i(res12_i), .pix_valid_o(pix_valid_o), .pix_line_o(pix_line_o),
        .pix_frame_o(pix_frame_o), .pix_data_o(pix_data_o), .link(link));
    readout_monitor i_readout_monitor (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .lane_data(link.lane_data), .lane_ctrl(link.lane_ctrl), .lane_clk(link.lane_clk),
        .spi_clk(link.spi_clk), .spi_en(link.spi_en), .spi_in(link.spi_in),
        .frame_req(link.frame_req), .system_reset_low(link.system_reset_low));
    always #50 mclk_i = ~mclk_i;
    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic cmd(input logic w, input logic t, input logic [6:0] a, input logic [7:0] d);
        while (cmd_ready_o !== 1'b1) tick();
        {cmd_valid_i, cmd_write_i, cmd_temp_i, cmd_addr_i, cmd_wdata_i} = {1'b1, w, t, a, d};
        tick();
        cmd_valid_i = 1'b0;
        if (!w) begin
            while (rd_valid_o !== 1'b1) tick();
        end
    endtask
    function automatic logic [15:0] pix(int r, int l, int c, int g, int o, bit m);
        int v;
        v = {r[5:0], l[1:0], c[3:0]};
        if (!m) v = v >> 2;
        v = (v << g) + o;
        if (v > (m ? CODE_MAX12 : CODE_MAX10)) v = m ? CODE_MAX12 : CODE_MAX10;
        return 16'(v);
    endfunction
    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        #9000000;
        n_fail++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'hF67AF1AB));
        repeat (8) @(posedge mclk_i);
        #1 rstn_i = 1'b1;
        for (int m = 0; m < 2; m++) begin
            cfg = '{8'h01, 8'($urandom % 4), 8'h00, 8'h01, 8'($urandom % 4), 8'($urandom), 8'(m)};
            if (m) begin
                cfg[REG_GAIN] = 8'h03;
                cfg[REG_OFFSET] = 8'hFF;
            end
            for (int i = 0; i < CFG_REGS; i++) cmd(1'b1, 1'b0, 7'(i), cfg[i]);
            // Capture width follows only once the sensor's slots use the new width
            while (i_image_sensor_end.s.res12 !== m[0]) tick();
            repeat (8) tick();
            res12_i = m[0];
            for (int i = 0; i <= CFG_REGS; i++) begin
                if (i == CFG_REGS) cmd(1'b1, 1'b0, 7'(i), 8'hA5);
                cmd(1'b0, 1'b0, 7'(i), 8'h00);
                check(rd_data_o, (i < CFG_REGS) ? {8'h00, cfg[i]} : 16'h0000);
            end
            temp_sample_i = 16'($urandom);
            cmd(1'b0, 1'b1, ADDR_TEMP_A, 8'h00);
            check(rd_data_o, temp_sample_i);
            check({15'h0000, busy_o}, 16'h0000);
            frame_start_i = 1'b1;
            while (link.frame_req !== 1'b1) tick();
            frame_start_i = 1'b0;
            for (int k = 0; k < 4; k++) begin
                for (int c = 0; c < COLS_PER_LANE; c++) begin
                    tick();
                    while (pix_valid_o !== 1'b1) tick();
                    if (k + c == 0) check({15'h0000, busy_o}, 16'h0001);
                    check({14'h0000, pix_line_o, pix_frame_o}, 16'h0003);
                    for (int l = 0; l < LANES; l++) check({4'h0, pix_data_o[l]}, pix(
                        cfg[REG_WIN_START] * 8 + 2 * k, l, c, cfg[REG_GAIN], cfg[REG_OFFSET], m[0]));
                end
            end
        end
        end_of_test();
    end
endmodule // test_image_readout_output_path
